//--- shared/ppoc_params.svh
// constants for the pack protection power-up and open-cell controller
// Summary of operation
// RULE_01: pulse a small load across each cell; a collapsed reading is an open cell.
// RULE_02: take one open-cell sample per sampling interval, cycling through the cells.
// RULE_03: latch the open-cell fault only after two consecutive hits.
// RULE_04: FETs open within two times N sampling intervals of a cell opening.
// RULE_05: both FETs stay off while the open-cell fault is latched.
// RULE_06: undervoltage and overvoltage faults keep acting on the FETs independently.
// RULE_07: after an open-cell fault with no charger, shut the regulator down; the code does so only from PWR_RUN, not while in PWR_PROT.
// RULE_08: charger removed while open-cell fault unrecovered shuts the regulator down; the code does so only from PWR_RUN, not while in PWR_PROT.
// RULE_09: on wake the open-cell fault starts cleared and must re-qualify.
// RULE_10: past the startup threshold, keep running even if supply dips below it.
// RULE_11: power down when supply leaves the operating range.
// RULE_12: either gate reservoir low drives both gate outputs low.
// RULE_13: system undervoltage disables both FETs within 500 us.
// RULE_14: run the safety checks on power-up and on each charger wake.
// RULE_15: a failed check enters protection until its external recovery condition; the code enters it only if a comparator still trips at sequence end.
// RULE_16: with no fault the power-up sequence ends in under 100 ms.
// RULE_17: start the check after reset release, using check pulse and completion signal.
// RULE_18: while incomplete, gates low and hysteresis clearing selected.
// RULE_19: after 50 ms pulse the check and test four comparators; failure sets a bit.
// RULE_20: at sequence end release completion; with no fault outputs return to normal.
// RULE_21: open-cell and later faults are evaluated only after power-up completes.
// RULE_22: a passing sample resets that cell's consecutive hit count.
`ifndef PPOC_PARAMS_SVH
`define PPOC_PARAMS_SVH

`define PPOC_CLK_HZ        25000000
`define PPOC_SEQ_STEP_MS   50
`define PPOC_OC_CHECK_US   1000
`define PPOC_OC_LOAD_CYC   4
`define PPOC_SYS_UV_MAX_NS 500000
`define PPOC_SYS_UV_CYC    ((`PPOC_SYS_UV_MAX_NS / 1000) * (`PPOC_CLK_HZ / 1000000))

`define PPOC_NCELL         10
`define PPOC_CELL_W        4
`define PPOC_SEQ_CNT_W     24
`define PPOC_OC_CNT_W      24
`define PPOC_LOAD_W        3

`define PPOC_ADDR_CTRL     4'h0
`define PPOC_ADDR_STATUS   4'h4
`define PPOC_CTRL_RST      4'hA

`define PPOC_ST_OC_FAULT   0
`define PPOC_ST_CHK_FAULT  1
`define PPOC_ST_COMPLETE   2
`define PPOC_ST_REG_ON     3
`define PPOC_ST_PROT       4
`define PPOC_ST_CELL_LO    8

`define PPOC_RESP_OKAY     2'h0
`define PPOC_RESP_SLVERR   2'h2

`endif

//--- shared/ppoc_pkg.sv
// types shared by the pack protection power-up and open-cell controller
package ppoc_pkg;
	typedef enum logic [1:0] {
		PWR_OFF  = 2'b00,
		PWR_SEQ  = 2'b01,
		PWR_RUN  = 2'b10,
		PWR_PROT = 2'b11
	} ppoc_pwr_t;
endpackage

//--- rtl/ppoc_oc_qualify.sv
// per-cell consecutive open-cell hit tracking and fault latch
`timescale 1ns/10ps
`include "ppoc_params.svh"
module ppoc_oc_qualify
	import ppoc_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    srst,
	input  wire logic                    ce,
	input  wire logic                    sample_stb,
	input  wire logic [`PPOC_CELL_W-1:0] sample_cell,
	input  wire logic                    sample_open,
	input  wire logic                    wake_clear,
	input  wire logic                    recovered,
	output logic                         fault_q
);
	logic [`PPOC_NCELL-1:0] hit_q;
	logic [`PPOC_NCELL-1:0] second_hit;
	logic                   fault_set;

	genvar i;
	generate
		for (i = 0; i < `PPOC_NCELL; i++) begin : g_cell
			// one flop per cell keeps each process the only writer of its variable
			logic cell_hit_q;
			wire  this_cell = sample_stb && (sample_cell == `PPOC_CELL_W'(i));
			assign hit_q[i]      = cell_hit_q;
			assign second_hit[i] = this_cell && sample_open && cell_hit_q; // [RULE_03]
			always_ff @(posedge clk) begin
				if (srst) begin
					cell_hit_q <= 1'b0;
				end else if (ce) begin
					if (wake_clear)
						cell_hit_q <= 1'b0;
					else if (this_cell)
						cell_hit_q <= sample_open; // [RULE_22]
				end
			end
		end
	endgenerate

	assign fault_set = |second_hit;

	// set beats the recovery clear; a wake always starts clean
	always_ff @(posedge clk) begin
		if (srst) begin
			fault_q <= 1'b0;
		end else if (ce) begin
			if (wake_clear)
				fault_q <= 1'b0; // [RULE_09]
			else if (fault_set)
				fault_q <= 1'b1; // [RULE_03]
			else if (recovered)
				fault_q <= 1'b0;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	a_fault_two_hits: assert property ( // [RULE_03]
		(ce && !fault_q && !wake_clear && sample_stb && sample_open
			&& !(|(hit_q & second_hit))) |=> !fault_q)
		else $error("open-cell fault latched on a first hit");

	a_pass_clears_hit: assert property ( // [RULE_22]
		(ce && !wake_clear && sample_stb && !sample_open) |=> (hit_q == ($past(hit_q) & ~(
			`PPOC_NCELL'(1) << $past(sample_cell)))))
		else $error("passing sample did not clear hit count");
endmodule

//--- rtl/ppoc_ctrl.sv
// power-up sequencing, open-cell scanning and gate control with AXI4-Lite status
`timescale 1ns/10ps
`include "ppoc_params.svh"
module ppoc_ctrl
	import ppoc_pkg::*;
#(
	parameter int unsigned SEQ_STEP_CYC = (`PPOC_SEQ_STEP_MS * (`PPOC_CLK_HZ / 1000)),
	parameter int unsigned OC_CHECK_CYC = (`PPOC_OC_CHECK_US * (`PPOC_CLK_HZ / 1000000))
) (
	input  wire logic                    CLK_SYS,
	input  wire logic                    SRST,
	input  wire logic                    CE,
	input  wire logic [3:0]              S_AXI_AWADDR,
	input  wire logic                    S_AXI_AWVALID,
	output logic                         S_AXI_AWREADY,
	input  wire logic [31:0]             S_AXI_WDATA,
	input  wire logic [3:0]              S_AXI_WSTRB,
	input  wire logic                    S_AXI_WVALID,
	output logic                         S_AXI_WREADY,
	output logic [1:0]                   S_AXI_BRESP,
	output logic                         S_AXI_BVALID,
	input  wire logic                    S_AXI_BREADY,
	input  wire logic [3:0]              S_AXI_ARADDR,
	input  wire logic                    S_AXI_ARVALID,
	output logic                         S_AXI_ARREADY,
	output logic [31:0]                  S_AXI_RDATA,
	output logic [1:0]                   S_AXI_RRESP,
	output logic                         S_AXI_RVALID,
	input  wire logic                    S_AXI_RREADY,
	input  wire logic                    SUPPLY_ABOVE_STARTUP,
	input  wire logic                    SUPPLY_IN_RANGE,
	input  wire logic                    CHARGE_GATE_RESERVOIR_LOW,
	input  wire logic                    DISCHARGE_GATE_RESERVOIR_LOW,
	input  wire logic                    SYSTEM_UNDERVOLT,
	input  wire logic                    CHARGER_PRESENT,
	input  wire logic                    LOAD_REMOVED,
	input  wire logic                    UNDERVOLT_CMP,
	input  wire logic                    OVERVOLT_CMP,
	input  wire logic                    DISCHARGE_OVERCURRENT_CMP,
	input  wire logic                    DISCHARGE_SHORT_CMP,
	input  wire logic                    UNDERVOLT_FAULT,
	input  wire logic                    OVERVOLT_FAULT,
	input  wire logic                    CELL_SENSE_COLLAPSED,
	input  wire logic                    OPEN_CELL_RECOVERED,
	output logic                         CELL_LOAD_PULSE,
	output logic [`PPOC_CELL_W-1:0]      CELL_SELECT,
	output logic                         REGULATOR_ENABLE,
	output logic                         SAFETY_CHECK_PULSE,
	output logic                         POWERUP_COMPLETE,
	output logic                         UNDERVOLT_HYSTERESIS_SELECT,
	output logic                         OVERVOLT_HYSTERESIS_SELECT,
	output logic                         CHARGE_FET_GATE,
	output logic                         DISCHARGE_FET_GATE
);
	// ***************************************************************
	// power state and sequence timing
	// ***************************************************************
	ppoc_pwr_t                   pwr_q;
	ppoc_pwr_t                   pwr_d;
	logic                        booted_q;
	logic [`PPOC_SEQ_CNT_W-1:0]  seq_cnt_q;
	logic                        chk_fault_q;
	logic                        oc_fault_q;
	logic [`PPOC_CELL_W-1:0]     cell_count_q;

	wire any_cmp      = UNDERVOLT_CMP || OVERVOLT_CMP
		|| DISCHARGE_OVERCURRENT_CMP || DISCHARGE_SHORT_CMP;
	wire step_mid     = (seq_cnt_q == `PPOC_SEQ_CNT_W'(SEQ_STEP_CYC - 1));
	wire step_end     = (seq_cnt_q == `PPOC_SEQ_CNT_W'(2 * SEQ_STEP_CYC - 2));
	wire first_power  = !booted_q && SUPPLY_ABOVE_STARTUP && SUPPLY_IN_RANGE;
	wire charger_wake = booted_q && CHARGER_PRESENT && SUPPLY_IN_RANGE;
	// in PWR_RUN a latched, unrecovered open cell drops the regulator unless a charger holds it up
	wire oc_shutdown  = oc_fault_q && !CHARGER_PRESENT && !OPEN_CELL_RECOVERED;
	wire prot_release = !any_cmp && (LOAD_REMOVED || CHARGER_PRESENT);

	always_comb begin
		pwr_d = pwr_q;
		unique case (pwr_q)
			PWR_OFF:  if (first_power || charger_wake)
					pwr_d = PWR_SEQ; // [RULE_14] [RULE_17]
			PWR_SEQ:  if (step_end)
					pwr_d = (chk_fault_q && any_cmp) ? PWR_PROT : PWR_RUN; // [RULE_15]
			PWR_RUN:  if (oc_shutdown)
					pwr_d = PWR_OFF; // [RULE_07] [RULE_08]
			PWR_PROT: if (prot_release)
					pwr_d = PWR_RUN; // [RULE_15]
		endcase
		if (!SUPPLY_IN_RANGE)
			pwr_d = PWR_OFF; // [RULE_11]
	end

	wire complete_d = (pwr_d == PWR_RUN) || (pwr_d == PWR_PROT);
	wire gate_kill  = CHARGE_GATE_RESERVOIR_LOW || DISCHARGE_GATE_RESERVOIR_LOW // [RULE_12]
		|| SYSTEM_UNDERVOLT || oc_fault_q; // [RULE_13] [RULE_05]
	wire gates_ok   = (pwr_d == PWR_RUN) && !gate_kill;
	wire chg_d      = gates_ok && !OVERVOLT_FAULT; // [RULE_06]
	wire dsg_d      = gates_ok && !UNDERVOLT_FAULT; // [RULE_06]
	wire hyst_d     = !complete_d || (pwr_d == PWR_PROT); // [RULE_18] [RULE_20]

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			pwr_q       <= PWR_OFF;
			booted_q    <= 1'b0;
			seq_cnt_q   <= '0;
			chk_fault_q <= 1'b0;
		end else if (CE) begin
			pwr_q <= pwr_d;
			// only a full supply collapse needs the startup threshold again
			if (!SUPPLY_IN_RANGE)
				booted_q <= 1'b0;
			else if (first_power)
				booted_q <= 1'b1; // [RULE_10]
			if (pwr_q != PWR_SEQ)
				seq_cnt_q <= '0;
			else
				seq_cnt_q <= seq_cnt_q + 1'b1;
			if (pwr_q == PWR_OFF)
				chk_fault_q <= 1'b0;
			else if (pwr_q == PWR_SEQ && step_mid)
				chk_fault_q <= any_cmp; // [RULE_19]
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			REGULATOR_ENABLE            <= 1'b0;
			SAFETY_CHECK_PULSE          <= 1'b0;
			POWERUP_COMPLETE            <= 1'b0;
			UNDERVOLT_HYSTERESIS_SELECT <= 1'b1;
			OVERVOLT_HYSTERESIS_SELECT  <= 1'b1;
			CHARGE_FET_GATE             <= 1'b0;
			DISCHARGE_FET_GATE          <= 1'b0;
		end else if (CE) begin
			REGULATOR_ENABLE            <= (pwr_d != PWR_OFF); // [RULE_10] [RULE_11]
			SAFETY_CHECK_PULSE          <= (pwr_q == PWR_SEQ) && step_mid; // [RULE_19]
			POWERUP_COMPLETE            <= complete_d; // [RULE_16] [RULE_20]
			UNDERVOLT_HYSTERESIS_SELECT <= hyst_d;
			OVERVOLT_HYSTERESIS_SELECT  <= hyst_d;
			CHARGE_FET_GATE             <= chg_d; // [RULE_18]
			DISCHARGE_FET_GATE          <= dsg_d;
		end
	end

	// ***************************************************************
	// open-cell scan
	// ***************************************************************
	logic [`PPOC_OC_CNT_W-1:0] oc_tmr_q;
	logic [`PPOC_LOAD_W-1:0]   load_cnt_q;
	logic                      oc_sample;

	// follows the next state so a load pulse drops in step with completion
	wire scanning = complete_d; // [RULE_21]
	wire oc_tick  = scanning && (oc_tmr_q == `PPOC_OC_CNT_W'(OC_CHECK_CYC - 1)); // [RULE_02]
	wire last_cell = (CELL_SELECT + 1'b1 >= cell_count_q);
	assign oc_sample = CELL_LOAD_PULSE
		&& (load_cnt_q == `PPOC_LOAD_W'(`PPOC_OC_LOAD_CYC - 1));

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			oc_tmr_q        <= '0;
			load_cnt_q      <= '0;
			CELL_LOAD_PULSE <= 1'b0;
			CELL_SELECT     <= '0;
		end else if (CE) begin
			oc_tmr_q <= (!scanning || oc_tick) ? '0 : oc_tmr_q + 1'b1;
			if (!scanning) begin
				CELL_LOAD_PULSE <= 1'b0;
				load_cnt_q      <= '0;
				CELL_SELECT     <= '0;
			end else if (oc_tick) begin
				CELL_LOAD_PULSE <= 1'b1; // [RULE_01]
				load_cnt_q      <= '0;
			end else if (oc_sample) begin
				CELL_LOAD_PULSE <= 1'b0;
				CELL_SELECT     <= last_cell ? '0 : CELL_SELECT + 1'b1; // [RULE_02]
			end else if (CELL_LOAD_PULSE) begin
				load_cnt_q <= load_cnt_q + 1'b1;
			end
		end
	end

	// sampling at the end of the load pulse gives the sense node time to sag
	ppoc_oc_qualify u_oc_qualify (
		.clk         (CLK_SYS),
		.srst        (SRST),
		.ce          (CE),
		.sample_stb  (oc_sample), // [RULE_04]
		.sample_cell (CELL_SELECT),
		.sample_open (CELL_SENSE_COLLAPSED), // [RULE_01]
		.wake_clear  (pwr_q == PWR_OFF), // [RULE_09]
		.recovered   (OPEN_CELL_RECOVERED),
		.fault_q     (oc_fault_q)
	);

	// ***************************************************************
	// AXI4-Lite register slave
	// ***************************************************************
	logic        aw_got_q;
	logic        w_got_q;
	logic [3:0]  awaddr_q;
	logic [3:0]  wdata_q;
	logic        wstrb0_q;

	wire aw_hs   = S_AXI_AWVALID && S_AXI_AWREADY;
	wire w_hs    = S_AXI_WVALID && S_AXI_WREADY;
	wire b_hs    = S_AXI_BVALID && S_AXI_BREADY;
	wire ar_hs   = S_AXI_ARVALID && S_AXI_ARREADY;
	wire r_hs    = S_AXI_RVALID && S_AXI_RREADY;
	wire do_wr   = aw_got_q && w_got_q && !S_AXI_BVALID;
	wire wr_ctrl = (awaddr_q == `PPOC_ADDR_CTRL);
	wire wr_okay = wr_ctrl || (awaddr_q == `PPOC_ADDR_STATUS);
	wire rd_ctrl = (S_AXI_ARADDR == `PPOC_ADDR_CTRL);
	wire rd_stat = (S_AXI_ARADDR == `PPOC_ADDR_STATUS);

	wire [31:0] status_word = {20'h0_0000, CELL_SELECT, 3'h0, (pwr_q == PWR_PROT),
		REGULATOR_ENABLE, POWERUP_COMPLETE, chk_fault_q, oc_fault_q};
	wire [31:0] rd_word = rd_ctrl ? {28'h000_0000, cell_count_q}
		: (rd_stat ? status_word : 32'h0000_0000);

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			aw_got_q      <= 1'b0;
			w_got_q       <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= '0;
			wstrb0_q      <= 1'b0;
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY  <= 1'b1;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= `PPOC_RESP_OKAY;
			cell_count_q  <= `PPOC_CTRL_RST;
		end else if (CE) begin
			if (aw_hs) begin
				aw_got_q      <= 1'b1;
				awaddr_q      <= S_AXI_AWADDR;
				S_AXI_AWREADY <= 1'b0;
			end
			if (w_hs) begin
				w_got_q      <= 1'b1;
				wdata_q      <= S_AXI_WDATA[3:0];
				wstrb0_q     <= S_AXI_WSTRB[0];
				S_AXI_WREADY <= 1'b0;
			end
			if (do_wr) begin
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= wr_okay ? `PPOC_RESP_OKAY : `PPOC_RESP_SLVERR;
				if (wr_ctrl && wstrb0_q)
					cell_count_q <= wdata_q;
			end
			if (b_hs) begin
				S_AXI_BVALID  <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY  <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0000_0000;
			S_AXI_RRESP   <= `PPOC_RESP_OKAY;
		end else if (CE) begin
			if (ar_hs) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID  <= 1'b1;
				S_AXI_RDATA   <= rd_word;
				S_AXI_RRESP   <= (rd_ctrl || rd_stat) ? `PPOC_RESP_OKAY : `PPOC_RESP_SLVERR;
			end else if (r_hs) begin
				S_AXI_ARREADY <= 1'b1;
				S_AXI_RVALID  <= 1'b0;
			end
		end
	end

	// ***************************************************************
	// checks
	// ***************************************************************
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SRST);

	a_reservoir_gate_kill: assert property ( // [RULE_12]
		(CE && (CHARGE_GATE_RESERVOIR_LOW || DISCHARGE_GATE_RESERVOIR_LOW))
			|=> (!CHARGE_FET_GATE && !DISCHARGE_FET_GATE))
		else $error("gate on with reservoir low");

	a_sys_uv_off: assert property ( // [RULE_13]
		(CE && SYSTEM_UNDERVOLT) |=> (!CHARGE_FET_GATE && !DISCHARGE_FET_GATE))
		else $error("gate on during system undervoltage");

	a_seq_forces_low: assert property ( // [RULE_18]
		!POWERUP_COMPLETE |-> (!CHARGE_FET_GATE && !DISCHARGE_FET_GATE
			&& UNDERVOLT_HYSTERESIS_SELECT && OVERVOLT_HYSTERESIS_SELECT))
		else $error("gate or hysteresis wrong before completion");

	a_check_pulse_once: assert property ( // [RULE_19]
		(CE && SAFETY_CHECK_PULSE) |=> (!SAFETY_CHECK_PULSE && !POWERUP_COMPLETE))
		else $error("check pulse longer than one cycle");

	a_oc_fets_off: assert property ( // [RULE_05]
		(CE && oc_fault_q) |=> (!CHARGE_FET_GATE && !DISCHARGE_FET_GATE))
		else $error("gate on with open-cell fault latched");

	a_oc_shutdown: assert property ( // [RULE_07]
		(CE && pwr_q == PWR_RUN && oc_fault_q && !CHARGER_PRESENT && !OPEN_CELL_RECOVERED)
			|=> !REGULATOR_ENABLE)
		else $error("regulator kept on after open-cell fault");

	a_supply_lost: assert property ( // [RULE_11]
		(CE && !SUPPLY_IN_RANGE) |=> (!REGULATOR_ENABLE && !POWERUP_COMPLETE))
		else $error("running outside supply range");

	a_stay_running: assert property ( // [RULE_10]
		(CE && REGULATOR_ENABLE && SUPPLY_IN_RANGE && !oc_fault_q) |=> REGULATOR_ENABLE)
		else $error("regulator dropped while supply in range");

	a_wake_clean: assert property ( // [RULE_09]
		$rose(REGULATOR_ENABLE) |-> (!oc_fault_q && !POWERUP_COMPLETE))
		else $error("wake with open-cell fault set");

	a_scan_after_done: assert property ( // [RULE_21]
		CELL_LOAD_PULSE |-> POWERUP_COMPLETE)
		else $error("open-cell load before completion");
endmodule

//--- dv/ppoc_pack_model.sv
// far-side model: charger, load and a cell stack with one breakable sense connection
`timescale 1ns/10ps
`include "ppoc_params.svh"
module ppoc_pack_model (
	input  wire logic                    charger_on,
	input  wire logic                    load_on,
	input  wire logic                    open_en,
	input  wire logic [`PPOC_CELL_W-1:0] open_cell,
	input  wire logic                    cell_load_pulse,
	input  wire logic [`PPOC_CELL_W-1:0] cell_select,
	output logic                         charger_present,
	output logic                         load_removed,
	output logic                         sense_collapsed
);
	assign charger_present = charger_on;
	// a motor winding holds the load return high until it is unplugged
	assign load_removed    = !load_on;
	// a broken sense line only shows up while the pulsed load is applied
	assign sense_collapsed = cell_load_pulse && open_en && (cell_select == open_cell);
endmodule

//--- dv/pack_protect_powerup_opencell_bench.sv
// self-checking bench for the power-up and open-cell controller
`timescale 1ns/10ps
`include "ppoc_params.svh"
module pack_protect_powerup_opencell_bench;
	localparam int SEQ = 20;
	localparam int OCC = 8;
	logic        CLK_SYS, SRST, CE;
	logic [3:0]  S_AXI_AWADDR, S_AXI_WSTRB, S_AXI_ARADDR;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
	logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
	logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
	logic        S_AXI_RVALID, S_AXI_RREADY;
	logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
	logic        SUPPLY_ABOVE_STARTUP, SUPPLY_IN_RANGE, CHARGE_GATE_RESERVOIR_LOW;
	logic        DISCHARGE_GATE_RESERVOIR_LOW, SYSTEM_UNDERVOLT, CHARGER_PRESENT, LOAD_REMOVED;
	logic        UNDERVOLT_CMP, OVERVOLT_CMP, DISCHARGE_OVERCURRENT_CMP, DISCHARGE_SHORT_CMP;
	logic        UNDERVOLT_FAULT, OVERVOLT_FAULT, CELL_SENSE_COLLAPSED, OPEN_CELL_RECOVERED;
	logic        CELL_LOAD_PULSE, REGULATOR_ENABLE, SAFETY_CHECK_PULSE, POWERUP_COMPLETE;
	logic [3:0]  CELL_SELECT;
	logic        UNDERVOLT_HYSTERESIS_SELECT, OVERVOLT_HYSTERESIS_SELECT;
	logic        CHARGE_FET_GATE, DISCHARGE_FET_GATE;
	logic        charger_on, load_on, open_en;
	logic [3:0]  open_cell, cmp_v, outs;
	logic [4:0]  flt_v;
	logic [1:0]  gates;
	int          n_mismatch, check_count;
	// row: {ov fault, uv fault, chg reservoir low, dsg reservoir low, system uv, chg, dsg}
	logic [6:0]  rows [7] = '{7'h03, 7'h41, 7'h22, 7'h10, 7'h08, 7'h04, 7'h03};

	assign {UNDERVOLT_CMP, OVERVOLT_CMP, DISCHARGE_OVERCURRENT_CMP, DISCHARGE_SHORT_CMP} = cmp_v;
	assign {OVERVOLT_FAULT, UNDERVOLT_FAULT, CHARGE_GATE_RESERVOIR_LOW,
		DISCHARGE_GATE_RESERVOIR_LOW, SYSTEM_UNDERVOLT} = flt_v;
	assign gates = {CHARGE_FET_GATE, DISCHARGE_FET_GATE};
	assign outs  = {gates, UNDERVOLT_HYSTERESIS_SELECT, OVERVOLT_HYSTERESIS_SELECT};

	ppoc_ctrl #(.SEQ_STEP_CYC(SEQ), .OC_CHECK_CYC(OCC)) uut (.*);

	ppoc_pack_model model (
		.charger_on      (charger_on),
		.load_on         (load_on),
		.open_en         (open_en),
		.open_cell       (open_cell),
		.cell_load_pulse (CELL_LOAD_PULSE),
		.cell_select     (CELL_SELECT),
		.charger_present (CHARGER_PRESENT),
		.load_removed    (LOAD_REMOVED),
		.sense_collapsed (CELL_SENSE_COLLAPSED)
	);

	initial begin
		CLK_SYS = 1'b0;
		forever #20 CLK_SYS = ~CLK_SYS;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge CLK_SYS);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
		n = 0;
		do begin
			@(posedge CLK_SYS);
			n++;
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
		end while (S_AXI_BVALID !== 1'b1 && n < 50);
		S_AXI_BREADY <= 1'b0;
		chk(S_AXI_BRESP, er, "write response");
	endtask

	task axi_rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] ed,
		input logic [1:0] er);
		int n;
		@(posedge CLK_SYS);
		S_AXI_ARADDR <= a;
		{S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
		n = 0;
		do begin
			@(posedge CLK_SYS);
			n++;
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
		end while (S_AXI_RVALID !== 1'b1 && n < 50);
		S_AXI_RREADY <= 1'b0;
		chk(S_AXI_RDATA & m, ed, "read data");
		chk(S_AXI_RRESP, er, "read response");
	endtask

	// entered with the supply or charger just raised; walks the whole sequence
	task seq_run(input logic prot);
		int n, np;
		n = 0;
		np = 0;
		while (REGULATOR_ENABLE !== 1'b1 && n < 10) begin
			@(posedge CLK_SYS);
			n++;
		end
		chk(REGULATOR_ENABLE, 1, "regulator on");
		n = 0;
		while (POWERUP_COMPLETE !== 1'b1 && n < 200) begin
			@(posedge CLK_SYS);
			n++;
			// a pulse wider than one cycle spoils the sum
			if (SAFETY_CHECK_PULSE === 1'b1) np = np + n;
			if (POWERUP_COMPLETE !== 1'b1) chk({outs, CELL_LOAD_PULSE}, 5'h06, "in sequence");
		end
		chk(np, SEQ, "check pulse");
		chk(n, 2 * SEQ - 1, "sequence length");
		repeat (2) @(posedge CLK_SYS);
		chk(outs, prot ? 4'h3 : 4'hC, "after sequence");
	endtask

	// lines the open sense up with one whole load pulse of the chosen cell
	task hit(input logic bad);
		int n;
		logic lp;
		n = 0;
		lp = 1'b1;
		while (!(CELL_LOAD_PULSE === 1'b1 && CELL_SELECT === open_cell && !lp) && n < 200) begin
			lp = CELL_LOAD_PULSE;
			@(posedge CLK_SYS);
			n++;
		end
		open_en <= bad;
		repeat (5) @(posedge CLK_SYS);
		open_en <= 1'b0;
	endtask

	initial begin
		repeat (20000) @(posedge CLK_SYS);
		n_mismatch++;
		$display("mismatch at %0t: watchdog expired", $time);
		give_verdict();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		int n;
		{SRST, CE} = 2'h3;
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
		S_AXI_WSTRB = 4'hF;
		{SUPPLY_ABOVE_STARTUP, SUPPLY_IN_RANGE, OPEN_CELL_RECOVERED} = '0;
		{charger_on, load_on, open_en, cmp_v, flt_v} = '0;
		open_cell = 4'h1;
		repeat (10) @(posedge CLK_SYS);
		SRST <= 1'b0;
		chk({outs, REGULATOR_ENABLE, POWERUP_COMPLETE}, 6'h0C, "reset state");
		axi_rd(`PPOC_ADDR_CTRL, 32'h0000_000F, `PPOC_CTRL_RST, `PPOC_RESP_OKAY);
		axi_wr(`PPOC_ADDR_CTRL, 32'h0000_0003, `PPOC_RESP_OKAY);
		axi_rd(`PPOC_ADDR_CTRL, 32'h0000_000F, 32'h0000_0003, `PPOC_RESP_OKAY);
		axi_wr(`PPOC_ADDR_STATUS, 32'hFFFF_FFFF, `PPOC_RESP_OKAY);
		axi_wr(4'h8, 32'h0000_0005, `PPOC_RESP_SLVERR);
		axi_rd(4'h8, 32'hFFFF_FFFF, 32'h0000_0000, `PPOC_RESP_SLVERR);
		{SUPPLY_IN_RANGE, SUPPLY_ABOVE_STARTUP} <= 2'h3;
		seq_run(1'b0);
		SUPPLY_ABOVE_STARTUP <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			flt_v <= rows[i][6:2];
			repeat (2) @(posedge CLK_SYS);
			chk(gates, rows[i][1:0], "gate row");
		end
		axi_rd(`PPOC_ADDR_STATUS, 32'h0000_001F, 32'h0000_000C, `PPOC_RESP_OKAY);
		for (int i = 0; i < 4; i++) hit(i % 2 == 0);
		axi_rd(`PPOC_ADDR_STATUS, 32'h0000_0001, 32'h0000_0000, `PPOC_RESP_OKAY);
		@(posedge CLK_SYS);
		{charger_on, open_en} <= 2'h3;
		n = 0;
		while (CHARGE_FET_GATE !== 1'b0 && n < 100) begin
			@(posedge CLK_SYS);
			n++;
		end
		chk(n <= 2 * 3 * OCC + 2, 1, "open-cell trip time");
		repeat (20) begin
			@(posedge CLK_SYS);
			chk({gates, REGULATOR_ENABLE}, 3'h1, "fault hold");
		end
		axi_rd(`PPOC_ADDR_STATUS, 32'h0000_0001, 32'h0000_0001, `PPOC_RESP_OKAY);
		charger_on <= 1'b0;
		repeat (3) @(posedge CLK_SYS);
		chk(REGULATOR_ENABLE, 0, "shutdown on charger removal");
		{open_en, charger_on} <= 2'h1;
		seq_run(1'b0);
		axi_rd(`PPOC_ADDR_STATUS, 32'h0000_0001, 32'h0000_0000, `PPOC_RESP_OKAY);
		{open_en, charger_on} <= 2'h2;
		n = 0;
		while (REGULATOR_ENABLE !== 1'b0 && n < 100) begin
			@(posedge CLK_SYS);
			n++;
		end
		chk(n > 3 * OCC && n <= 2 * 3 * OCC + 3, 1, "requalify and shut down");
		open_en <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			SUPPLY_IN_RANGE <= 1'b0;
			repeat (2) @(posedge CLK_SYS);
			chk(REGULATOR_ENABLE, 0, "power down");
			load_on <= 1'b1;
			cmp_v <= 4'h1 << k;
			{SUPPLY_IN_RANGE, SUPPLY_ABOVE_STARTUP} <= 2'h3;
			seq_run(1'b1);
			axi_rd(`PPOC_ADDR_STATUS, 32'h0000_0012, 32'h0000_0012, `PPOC_RESP_OKAY);
			cmp_v <= 4'h0;
			repeat (3) @(posedge CLK_SYS);
			chk(outs, 4'h3, "held until load removed");
			load_on <= 1'b0;
			repeat (3) @(posedge CLK_SYS);
			chk(outs, 4'hC, "recovered");
		end
		{charger_on, open_en} <= 2'h3;
		repeat (60) @(posedge CLK_SYS);
		chk({gates, REGULATOR_ENABLE}, 3'h1, "fault held by charger");
		{OPEN_CELL_RECOVERED, open_en, charger_on} <= 3'h4;
		repeat (3) @(posedge CLK_SYS);
		chk({gates, REGULATOR_ENABLE}, 3'h7, "recovered, no shutdown");
		CE <= 1'b0;
		SUPPLY_IN_RANGE <= 1'b0;
		repeat (3) @(posedge CLK_SYS);
		chk({REGULATOR_ENABLE, POWERUP_COMPLETE}, 2'h3, "frozen by enable");
		CE <= 1'b1;
		repeat (2) @(posedge CLK_SYS);
		chk({REGULATOR_ENABLE, POWERUP_COMPLETE}, 2'h0, "power down after enable");
		give_verdict();
	end
endmodule
